// >>> sgc_consts.vh
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
// register offsets on the host register port
`define SGC_OFS_CTRL_A      8'h03
`define SGC_OFS_CTRL_B      8'h04
// control register A fields
`define SGC_A_LARGE_FRAME   6
`define SGC_A_TX_PAUSE_DIS  5
`define SGC_A_RX_PAUSE_DIS  4
`define SGC_A_LEN_CHECK     3
`define SGC_A_AGING_EN      2
`define SGC_A_FAST_AGING    1
`define SGC_A_AGGR_BACKOFF  0
`define SGC_A_WMASK         8'h7F
`define SGC_A_RESET         8'h04
// control register B fields
`define SGC_B_VLAN_DISCARD  7
`define SGC_B_BCAST_ONLY    6
`define SGC_B_BP_CARRIER    5
`define SGC_B_FAIR_MODE     4
`define SGC_B_NO_EXC_DROP   3
`define SGC_B_SIZE_CHK_DIS  1
`define SGC_B_WMASK         8'hFA
`define SGC_B_RESET         8'hF0
// frame size limits in bytes
`define SGC_LEN_2KB         12'h800
`define SGC_LEN_ANY_MAX     12'h600
`define SGC_LEN_TAGGED_MAX  12'h5F2
`define SGC_LEN_UNTAG_MAX   12'h5EE
`define SGC_LEN_FIELD_LIM   12'h5DC
// collision limit
`define SGC_COLL_LIMIT      5'h10
// fast aging period: 800 us at 100 ns per cycle, rounded down
`define SGC_FAST_AGE_US     800
`define SGC_CLK_NS          100
`define SGC_FAST_AGE_CYC    ((`SGC_FAST_AGE_US * 1000) / `SGC_CLK_NS)
`define SGC_AGE_CNT_W       13
`endif

// >>> sgc_frame_policy.v
`timescale 1ns/1ps
`include "sgc_consts.vh"
// per-frame drop decisions from the latched control snapshot
module sgc_frame_policy (
  // clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // control snapshot
  input  wire [7:0]  ctrlA,
  input  wire [7:0]  ctrlB,
  // frame descriptor
  input  wire        frameValid,
  input  wire [11:0] frameLen,
  input  wire        frameTagged,
  input  wire        frameCpuTag,
  input  wire        frameLenFieldIsLen,
  input  wire [11:0] frameLenField,
  input  wire [4:0]  frameCollisions,
  input  wire        frameKnownUnicast,
  input  wire        frameMirrored,
  input  wire        frameCrossesVlan,
  // result
  output reg         dropValid,
  output reg         dropFrame
);
  reg overSize;
  reg lenMismatch;
  reg vlanBlock;
  reg collDrop;

  always @* begin
    if (ctrlA[`SGC_A_LARGE_FRAME])
      overSize = (frameLen > `SGC_LEN_2KB); // RL1
    else if (ctrlB[`SGC_B_SIZE_CHK_DIS])
      overSize = (frameLen > `SGC_LEN_ANY_MAX); // RL18
    else if (frameTagged)
      overSize = !frameCpuTag && (frameLen > `SGC_LEN_TAGGED_MAX); // RL17
    else
      overSize = (frameLen > `SGC_LEN_UNTAG_MAX); // RL17
    lenMismatch = ctrlA[`SGC_A_LEN_CHECK] && frameLenFieldIsLen &&
                  (frameLenField < `SGC_LEN_FIELD_LIM) && (frameLenField != frameLen); // RL5
    if (ctrlB[`SGC_B_VLAN_DISCARD])
      vlanBlock = frameCrossesVlan; // RL9
    else
      vlanBlock = frameCrossesVlan && !frameKnownUnicast; // RL10
    if (frameMirrored && frameKnownUnicast && frameCrossesVlan)
      vlanBlock = 1'b1; // RL11
    collDrop = !ctrlB[`SGC_B_NO_EXC_DROP] && (frameCollisions >= `SGC_COLL_LIMIT); // RL16
  end

  always @(posedge core_clk) begin
    if (srst) begin
      dropValid <= 1'b0;
      dropFrame <= 1'b0;
    end else begin
      dropValid <= frameValid;
      dropFrame <= frameValid && (overSize || lenMismatch || vlanBlock || collDrop);
    end
  end
endmodule

// >>> sgc_global_ctrl.v
`timescale 1ns/1ps
`include "sgc_consts.vh"
// Notes on behaviour
// RL1 - large-frame bit allows frames up to 2kb
// RL2 - tx pause disable forces transmit flow control off
// RL3 - rx pause disable forces receive flow control off
// RL4 - one strap sets both pause bits' reset
// RL5 - length check drops mismatched short length frames
// RL6 - aging runs only while aging bit set
// RL7 - fast aging uses 800 us period
// RL8 - bit 0 picks aggressive half-duplex back-off
// RL9 - discard bit confines all frames to port-VLAN
// RL10 - clear discard lets known unicast cross
// RL11 - mirrored single-destination frames crossing VLAN drop
// RL12 - storm limit counts broadcast only or multicast
// RL13 - back pressure carrier-sense or collision based
// RL14 - fair mode drops non-flow-controlled port frames
// RL15 - unfair mode flow controls flow-controlled port
// RL16 - drop frames after 16 collisions unless set
// RL17 - size check limits tagged 1522, untagged 1518; tagged frames with a CPU tag get no size limit
// RL18 - size check disabled accepts up to 1536
// RL19 - reserved bits read zero, read-only
// RL20 - new settings apply at next frame start, except the aging and fast aging bits, which apply at once
module sgc_global_ctrl (
  // clock and reset
  input  wire        core_clk,
  input  wire        srst,
  // strap for pause disable defaults
  input  wire        pauseDisStrap,
  // host register port
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  output reg  [7:0]  regRdata,
  // per-port negotiation results and frame start
  input  wire [4:0]  autoNegTxPause,
  input  wire [4:0]  autoNegRxPause,
  input  wire        frameStart,
  // contention from the forwarding engine
  input  wire        egressContention,
  // frame descriptor
  input  wire        frameValid,
  input  wire [11:0] frameLen,
  input  wire        frameTagged,
  input  wire        frameCpuTag,
  input  wire        frameLenFieldIsLen,
  input  wire [11:0] frameLenField,
  input  wire [4:0]  frameCollisions,
  input  wire        frameKnownUnicast,
  input  wire        frameMirrored,
  input  wire        frameCrossesVlan,
  // policy outputs
  output reg  [4:0]  txPauseEn,
  output reg  [4:0]  rxPauseEn,
  output reg         agingTick,
  output reg         fastAgingActive,
  output reg         aggressiveBackoff,
  output reg         stormCountMulticast,
  output reg         backPressureCarrier,
  output reg         dropNonFlowCtrl,
  output reg         pauseFlowCtrlPort,
  output reg         dropValid,
  output reg         dropFrame
);
  localparam AGE_MAX = `SGC_FAST_AGE_CYC - 1;

  reg [7:0] ctrlA;
  reg [7:0] ctrlB;
  reg [7:0] liveA;
  reg [7:0] liveB;
  reg       strapSync1;
  reg       strapSync2;
  reg       strapPending;
  reg [`SGC_AGE_CNT_W-1:0] ageCnt;
  reg [`SGC_AGE_CNT_W-1:0] next_ageCnt;
  wire      policyDropValid;
  wire      policyDrop;

  // strap synchroniser
  always @(posedge core_clk) begin
    strapSync1 <= pauseDisStrap;
    strapSync2 <= strapSync1;
  end

  // register file
  always @(posedge core_clk) begin
    if (srst) begin
      ctrlA        <= `SGC_A_RESET;
      ctrlB        <= `SGC_B_RESET;
      strapPending <= 1'b1;
      // pause defaults track the strap while reset is held
      ctrlA[`SGC_A_TX_PAUSE_DIS] <= strapSync2; // RL4
      ctrlA[`SGC_A_RX_PAUSE_DIS] <= strapSync2; // RL4
    end else begin
      if (strapPending) begin
        strapPending <= 1'b0;
        ctrlA[`SGC_A_TX_PAUSE_DIS] <= strapSync2; // RL4
        ctrlA[`SGC_A_RX_PAUSE_DIS] <= strapSync2; // RL4
      end
      if (regWrite && regAddr == `SGC_OFS_CTRL_A) begin
        ctrlA <= regWdata & `SGC_A_WMASK; // RL19
        strapPending <= 1'b0;
      end
      if (regWrite && regAddr == `SGC_OFS_CTRL_B)
        ctrlB <= regWdata & `SGC_B_WMASK; // RL19
    end
  end

  always @(posedge core_clk) begin
    if (srst)
      regRdata <= 8'h00;
    else if (regRead) begin
      case (regAddr)
        `SGC_OFS_CTRL_A: regRdata <= ctrlA;
        `SGC_OFS_CTRL_B: regRdata <= ctrlB;
        default:         regRdata <= 8'h00;
      endcase
    end
  end

  // snapshot taken at frame start so in-flight frames keep old settings
  always @(posedge core_clk) begin
    if (srst) begin
      liveA <= `SGC_A_RESET;
      liveB <= `SGC_B_RESET;
      liveA[`SGC_A_TX_PAUSE_DIS] <= strapSync2; // RL4
      liveA[`SGC_A_RX_PAUSE_DIS] <= strapSync2; // RL4
    end else if (frameStart) begin
      liveA <= ctrlA; // RL20
      liveB <= ctrlB; // RL20
    end
  end

  // aging tick generator
  always @* begin
    next_ageCnt = ageCnt;
    if (!ctrlA[`SGC_A_AGING_EN])
      next_ageCnt = {`SGC_AGE_CNT_W{1'b0}}; // RL6
    else if (ageCnt >= AGE_MAX[`SGC_AGE_CNT_W-1:0])
      next_ageCnt = {`SGC_AGE_CNT_W{1'b0}};
    else
      next_ageCnt = ageCnt + 1'b1;
  end

  always @(posedge core_clk) begin
    if (srst) begin
      ageCnt    <= {`SGC_AGE_CNT_W{1'b0}};
      agingTick <= 1'b0;
    end else begin
      ageCnt    <= next_ageCnt;
      agingTick <= ctrlA[`SGC_A_AGING_EN] && ctrlA[`SGC_A_FAST_AGING] &&
                   (ageCnt >= AGE_MAX[`SGC_AGE_CNT_W-1:0]); // RL7
    end
  end

  // policy outputs
  always @(posedge core_clk) begin
    if (srst) begin
      txPauseEn           <= 5'h00;
      rxPauseEn           <= 5'h00;
      fastAgingActive     <= 1'b0;
      aggressiveBackoff   <= 1'b0;
      stormCountMulticast <= 1'b0;
      backPressureCarrier <= 1'b1;
      dropNonFlowCtrl     <= 1'b0;
      pauseFlowCtrlPort   <= 1'b0;
    end else begin
      txPauseEn           <= liveA[`SGC_A_TX_PAUSE_DIS] ? 5'h00 : autoNegTxPause; // RL2
      rxPauseEn           <= liveA[`SGC_A_RX_PAUSE_DIS] ? 5'h00 : autoNegRxPause; // RL3
      fastAgingActive     <= ctrlA[`SGC_A_AGING_EN] && ctrlA[`SGC_A_FAST_AGING]; // RL7
      aggressiveBackoff   <= liveA[`SGC_A_AGGR_BACKOFF]; // RL8
      stormCountMulticast <= !liveB[`SGC_B_BCAST_ONLY]; // RL12
      backPressureCarrier <= liveB[`SGC_B_BP_CARRIER]; // RL13
      dropNonFlowCtrl     <= egressContention && liveB[`SGC_B_FAIR_MODE]; // RL14
      pauseFlowCtrlPort   <= egressContention && !liveB[`SGC_B_FAIR_MODE]; // RL15
    end
  end

  sgc_frame_policy u_policy (
    .core_clk           (core_clk),
    .srst               (srst),
    .ctrlA              (liveA),
    .ctrlB              (liveB),
    .frameValid         (frameValid),
    .frameLen           (frameLen),
    .frameTagged        (frameTagged),
    .frameCpuTag        (frameCpuTag),
    .frameLenFieldIsLen (frameLenFieldIsLen),
    .frameLenField      (frameLenField),
    .frameCollisions    (frameCollisions),
    .frameKnownUnicast  (frameKnownUnicast),
    .frameMirrored      (frameMirrored),
    .frameCrossesVlan   (frameCrossesVlan),
    .dropValid          (policyDropValid),
    .dropFrame          (policyDrop)
  );

  always @(posedge core_clk) begin
    if (srst) begin
      dropValid <= 1'b0;
      dropFrame <= 1'b0;
    end else begin
      dropValid <= policyDropValid;
      dropFrame <= policyDrop;
    end
  end
endmodule

// >>> sgc_global_ctrl_assertions.sv
`timescale 1ns/1ps
module sgc_global_ctrl_chk (
  // clock and reset
  input wire        core_clk,
  input wire        srst,
  // inputs
  input wire        regRead,
  input wire [7:0]  regAddr,
  input wire [4:0]  autoNegTxPause,
  input wire        frameStart,
  input wire        egressContention,
  input wire        frameValid,
  input wire [11:0] frameLen,
  input wire        frameTagged,
  input wire        frameCpuTag,
  // outputs
  input wire [7:0]  regRdata,
  input wire [4:0]  txPauseEn,
  input wire        agingTick,
  input wire        fastAgingActive,
  input wire        backPressureCarrier,
  input wire        stormCountMulticast,
  input wire        dropNonFlowCtrl,
  input wire        pauseFlowCtrlPort,
  input wire        dropValid,
  input wire        dropFrame
);
  reg [12:0] gap;
  reg        seen;
  // cycles since the last fast aging tick
  always @(posedge core_clk) begin
    if (srst || !fastAgingActive || agingTick)
      gap <= 13'h0000;
    else
      gap <= gap + 13'h0001;
    if (srst || !fastAgingActive)
      seen <= 1'b0;
    else if (agingTick)
      seen <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_tx_pause_gate: assert property ((txPauseEn & ~$past(autoNegTxPause)) == 5'h00)
    else $error("tx pause not negotiated");
  chk_fair_mode_pick: assert property (!$past(srst) |->
    (dropNonFlowCtrl ^ pauseFlowCtrlPort) == $past(egressContention))
    else $error("contention result wrong");
  chk_drop_latency: assert property (frameValid |-> ##2 dropValid)
    else $error("drop decision late");
  chk_drop_cause: assert property (dropValid |-> $past(frameValid, 2))
    else $error("drop decision without frame");
  chk_oversize_drop: assert property (frameValid && !(frameTagged && frameCpuTag) && frameLen > 12'h800 |-> ##2 dropFrame)
    else $error("oversize frame kept");
  chk_reserved_zero: assert property (regRead |=>
    (regRdata & ($past(regAddr) == 8'h03 ? 8'h80 : $past(regAddr) == 8'h04 ? 8'h05 : 8'hFF)) == 8'h00)
    else $error("reserved bits set");
  chk_snapshot_hold: assert property ($changed({backPressureCarrier, stormCountMulticast}) |->
    $past(frameStart, 2) || $past(frameStart, 3))
    else $error("setting changed without frame start");
  chk_aging_period: assert property (agingTick && seen |-> gap == 13'h1F3F)
    else $error("fast aging period wrong");
  cover property (dropValid && dropFrame);
  cover property (agingTick && seen);
  cover property (dropNonFlowCtrl);
endmodule

bind sgc_global_ctrl sgc_global_ctrl_chk u_chk (
  .core_clk            (core_clk),
  .srst                (srst),
  .regRead             (regRead),
  .regAddr             (regAddr),
  .autoNegTxPause      (autoNegTxPause),
  .frameStart          (frameStart),
  .egressContention    (egressContention),
  .frameValid          (frameValid),
  .frameLen            (frameLen),
  .frameTagged         (frameTagged),
  .frameCpuTag         (frameCpuTag),
  .regRdata            (regRdata),
  .txPauseEn           (txPauseEn),
  .agingTick           (agingTick),
  .fastAgingActive     (fastAgingActive),
  .backPressureCarrier (backPressureCarrier),
  .stormCountMulticast (stormCountMulticast),
  .dropNonFlowCtrl     (dropNonFlowCtrl),
  .pauseFlowCtrlPort   (pauseFlowCtrlPort),
  .dropValid           (dropValid),
  .dropFrame           (dropFrame)
);

// >>> sgc_tb.sv
`timescale 1ns/1ps
module tb;
  reg         core_clk = 1'b0;
  reg         srst = 1'b1;
  reg         pauseDisStrap = 1'b1;
  reg         regWrite = 1'b0;
  reg         regRead = 1'b0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [7:0]  regWdata = 8'h00;
  reg  [4:0]  autoNegTxPause = 5'h1F;
  reg  [4:0]  autoNegRxPause = 5'h1F;
  reg         frameStart = 1'b0;
  reg         egressContention = 1'b1;
  reg         frameValid = 1'b0;
  reg  [5:0]  fl = 6'h00;
  reg  [11:0] frameLen = 12'h000;
  reg  [11:0] frameLenField = 12'h000;
  reg  [4:0]  frameCollisions = 5'h00;
  wire        frameTagged, frameCpuTag, frameLenFieldIsLen, frameKnownUnicast, frameMirrored, frameCrossesVlan;
  wire [7:0]  regRdata;
  wire [4:0]  txPauseEn, rxPauseEn;
  wire        agingTick, fastAgingActive, aggressiveBackoff, stormCountMulticast, backPressureCarrier;
  wire        dropNonFlowCtrl, pauseFlowCtrlPort, dropValid, dropFrame;
  integer     mismatches = 0, checks = 0, n, t;
  assign {frameTagged, frameCpuTag, frameLenFieldIsLen, frameKnownUnicast, frameMirrored, frameCrossesVlan} = fl;
  always #50 core_clk = ~core_clk;
  sgc_global_ctrl uut (.*);
  task tally_and_finish;
    begin
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [11:0] seen, input [11:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      tick(1);
      regWrite = 1'b0;
      tick(1);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      regAddr = a;
      regRead = 1'b1;
      tick(1);
      regRead = 1'b0;
      chk(regRdata, e);
      tick(1);
    end
  endtask
  task cfg(input [7:0] a, input [7:0] b);
    begin
      wr(8'h03, a);
      wr(8'h04, b);
      frameStart = 1'b1;
      tick(1);
      frameStart = 1'b0;
      tick(3);
    end
  endtask
  task frm(input [5:0] f, input [11:0] len, input e);
    begin
      fl = f;
      frameLen = len;
      frameValid = 1'b1;
      tick(1);
      frameValid = 1'b0;
      t = 0;
      while (dropValid !== 1'b1 && t < 8) begin
        tick(1);
        t = t + 1;
      end
      chk(dropValid, 1'b1);
      if (t == 8)
        tally_and_finish;
      chk(dropFrame, e);
    end
  endtask
  task cnt(input integer k);
    begin
      n = 0;
      repeat (k) begin
        tick(1);
        n = n + agingTick;
      end
    end
  endtask
  initial begin
    tick(16);
    srst = 1'b0;
    rd(8'h03, 8'h34);
    rd(8'h04, 8'hF0);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'h7F);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'hFA);
    wr(8'h05, 8'h5A);
    rd(8'h05, 8'h00);
    autoNegRxPause = 5'h15;
    cfg(8'h24, 8'hF0);
    chk({txPauseEn, rxPauseEn}, {5'h00, 5'h15});
    chk({aggressiveBackoff, stormCountMulticast, backPressureCarrier, dropNonFlowCtrl, pauseFlowCtrlPort}, 5'h06);
    wr(8'h04, 8'h00);
    tick(3);
    chk({aggressiveBackoff, stormCountMulticast, backPressureCarrier, dropNonFlowCtrl, pauseFlowCtrlPort}, 5'h06);
    autoNegTxPause = 5'h0A;
    cfg(8'h15, 8'h00);
    chk({txPauseEn, rxPauseEn}, {5'h0A, 5'h00});
    chk({aggressiveBackoff, stormCountMulticast, backPressureCarrier, dropNonFlowCtrl, pauseFlowCtrlPort}, 5'h19);
    egressContention = 1'b0;
    tick(2);
    chk({dropNonFlowCtrl, pauseFlowCtrlPort}, 2'h0);
    egressContention = 1'b1;
    cfg(8'h04, 8'hF0);
    frm(6'h00, 12'h5EE, 1'b0);
    frm(6'h00, 12'h5EF, 1'b1);
    frm(6'h20, 12'h5F2, 1'b0);
    frm(6'h20, 12'h5F3, 1'b1);
    frm(6'h30, 12'h5FA, 1'b0);
    frm(6'h05, 12'h040, 1'b1);
    frameLenField = 12'h064;
    frm(6'h08, 12'h040, 1'b0);
    frameCollisions = 5'h10;
    frm(6'h00, 12'h040, 1'b1);
    cfg(8'h0C, 8'h7A);
    frm(6'h00, 12'h040, 1'b0);
    frameCollisions = 5'h0F;
    frm(6'h05, 12'h040, 1'b0);
    frm(6'h01, 12'h040, 1'b1);
    frm(6'h07, 12'h040, 1'b1);
    frm(6'h00, 12'h600, 1'b0);
    frm(6'h00, 12'h601, 1'b1);
    frm(6'h08, 12'h040, 1'b1);
    frameLenField = 12'h5DC;
    frm(6'h08, 12'h040, 1'b0);
    cfg(8'h44, 8'hF0);
    frm(6'h00, 12'h800, 1'b0);
    frm(6'h00, 12'h801, 1'b1);
    cfg(8'h06, 8'hF0);
    cnt(16000);
    chk(n[11:0], 12'h002);
    cfg(8'h02, 8'hF0);
    cnt(8000);
    chk({fastAgingActive, n[3:0]}, 5'h00);
    pauseDisStrap = 1'b0;
    srst = 1'b1;
    tick(3);
    srst = 1'b0;
    rd(8'h03, 8'h04);
    tally_and_finish;
  end
endmodule
